// ### include/mbf_pkg.sv
// Purpose: types of the function handler
// Assumes: mbf_regs.svh on the include path
// Notes: state of the main module is one packed struct
package mbf_pkg;
    // ======================================================================
    // states and reply kinds
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_RX = 4'h1,
        S_CHECK = 4'h2,
        S_WR_HI = 4'h3,
        S_WR_LO = 4'h4,
        S_WR_DO = 4'h5,
        S_TXA = 4'h6,
        S_TXB = 4'h7
    } mbf_state_e;

    typedef enum logic [1:0] {
        K_ECHO = 2'h0,
        K_READ = 2'h1,
        K_WRN = 2'h2,
        K_ERR = 2'h3
    } mbf_kind_e;

    typedef struct packed {
        mbf_state_e st;
        mbf_kind_e kind;
        logic rx_rdy;
        logic [6:0] n;
        logic [15:0] crc;
        logic [7:0] dst;
        logic [7:0] func;
        logic [15:0] start;
        logic [15:0] qty;
        logic [7:0] bcnt;
        logic [4:0] k;
        logic [7:0] hi;
        logic [7:0] exc;
        logic [5:0] tx_i;
        logic wstb;
        logic [15:0] waddr;
        logic [15:0] wdata;
        logic [8:0] d0;
        logic [8:0] d1;
        logic v0;
        logic v1;
    } mbf_st_s;
endpackage

// ### include/mbf_regs.svh
// Purpose: constants of the function handler (codes, frame offsets, limits)
// Assumes: included by the handler module only
// Notes: frame offsets are byte positions counted from the address byte
`ifndef MBF_REGS_SVH
`define MBF_REGS_SVH

// ==========================================================================
// crc and function codes
`define MBF_CRC_INIT 16'hFFFF
`define MBF_CRC_POLY 16'hA001
`define MBF_FC_READ 8'h03
`define MBF_FC_WR1 8'h06
`define MBF_FC_LOOP 8'h08
`define MBF_FC_WRN 8'h10
`define MBF_EXC_FLAG 8'h80
`define MBF_EXC_FUNC 8'h01
`define MBF_EXC_ADDR 8'h02
`define MBF_EXC_DATA 8'h03
`define MBF_BCAST 8'h00

// ==========================================================================
// request byte positions
`define MBF_IX_ADDR 7'h00
`define MBF_IX_FUNC 7'h01
`define MBF_IX_AHI 7'h02
`define MBF_IX_ALO 7'h03
`define MBF_IX_QHI 7'h04
`define MBF_IX_QLO 7'h05
`define MBF_IX_BCNT 7'h06
`define MBF_DATA_WR1 6'h04
`define MBF_DATA_WRN 6'h07

// ==========================================================================
// lengths and limits
`define MBF_LEN_MIN 7'h04
`define MBF_LEN_FIX 7'h08
`define MBF_LEN_WRN_HDR 7'h09
`define MBF_FRM_MAX 7'h40
`define MBF_MAX_QTY 16'h0010
`define MBF_TX_RDATA 6'h03
`define MBF_TX_COPY 6'h06
`define MBF_TX_WRN_LAST 6'h07
`define MBF_TX_ERR_LAST 6'h04
`define MBF_REG_AW 8
`define MBF_FRM_AW 6

`endif

// ### src/mbf_handler.sv
// Purpose: function handler of a serial slave: read, write one, loopback, write many
// Assumes: bytes of one request arrive on rx, last byte flagged by rx_last
// Notes: replies leave through a two-entry buffer on tx; crc bytes low first
// Behaviour
// RULE1: a read returns the asked number of registers taken in order from the start address.
// RULE2: each 16-bit value travels as its upper byte followed by its lower byte.
// RULE3: the master sets the byte count of a write-many request to twice the quantity.
// RULE4: a read reply carries a byte count of twice the number of registers returned.
// RULE5: a refused request gets address, function plus 80H, an error code and the crc.
// RULE6: a write-one stores the value and replies with the request bytes unchanged.
// RULE7: a loopback request is echoed back without any change.
// RULE8: the master picks the test code and data of each loopback request.
// RULE9: a write-many stores consecutive values and replies with address, function, start, quantity.
// RULE10: the register map can be read by the read function and written by both writes.
// RULE11: the crc accumulator starts at all ones before the first byte of a frame.
// RULE12: a request to address zero is acted on but never answered.
// RULE13: a frame with a bad crc is dropped with no reply at all.
`timescale 1ns/100ps
`include "mbf_regs.svh"
module mbf_handler #(
    parameter int AW = `MBF_REG_AW
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] dev_addr,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_last,
    output logic rx_ready,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready,
    output logic reg_wr_stb,
    output logic [AW-1:0] reg_wr_addr,
    output logic [15:0] reg_wr_data
);
    localparam logic [16:0] DEPTH = 17'(1 << AW);

    mbf_pkg::mbf_st_s s_r;
    mbf_pkg::mbf_st_s s_nxt;
    logic [7:0] frm_rdata;
    logic [15:0] reg_rdata;
    logic [5:0] frm_raddr;
    logic [15:0] reg_raddr;
    logic rx_take;
    logic pop;
    logic push;
    logic [8:0] push_d;
    logic [7:0] tb;
    logic tl;
    logic crc_hold; // crc bytes of read, write-many and error replies leave the accumulator untouched
    logic [5:0] q2;
    logic [5:0] roff;

    // ======================================================================
    // helpers
    function automatic logic [15:0] crc16_upd(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] x;
        x = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ `MBF_CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    function automatic logic [5:0] data_base(input logic [7:0] f);
        return (f == `MBF_FC_WRN) ? `MBF_DATA_WRN : `MBF_DATA_WR1;
    endfunction

    // ======================================================================
    // memories: request frame and register map
    assign rx_take = rx_valid && s_r.rx_rdy;
    assign q2 = {s_r.qty[4:0], 1'b0};
    assign roff = s_r.tx_i - `MBF_TX_RDATA;

    // frame read address follows the write loop, else the reply index
    always_comb begin
        frm_raddr = s_r.tx_i;
        if (s_r.st == mbf_pkg::S_WR_HI) begin
            frm_raddr = data_base(s_r.func) + {s_r.k, 1'b0};
        end else if (s_r.st == mbf_pkg::S_WR_LO) begin
            frm_raddr = data_base(s_r.func) + {s_r.k, 1'b0} + 6'h01;
        end
        reg_raddr = s_r.start + {11'h000, roff[5:1]}; // see RULE1
    end

    mbf_ram #(.W(8), .AW(`MBF_FRM_AW)) u_frame (
        .clk(clk),
        .rstn(rstn),
        .we(rx_take && (s_r.n < `MBF_FRM_MAX)),
        .waddr(s_r.n[5:0]),
        .wdata(rx_data),
        .raddr(frm_raddr),
        .rdata(frm_rdata)
    );

    mbf_ram #(.W(16), .AW(AW)) u_regs (
        .clk(clk),
        .rstn(rstn),
        .we(s_r.wstb),
        .waddr(s_r.waddr[AW-1:0]),
        .wdata(s_r.wdata),
        .raddr(reg_raddr[AW-1:0]),
        .rdata(reg_rdata)
    );

    // ======================================================================
    // reply byte selection
    always_comb begin
        tb = frm_rdata;
        tl = 1'b0;
        crc_hold = 1'b0;
        case (s_r.kind)
            mbf_pkg::K_ECHO: begin
                tl = ({1'b0, s_r.tx_i} == s_r.n - 7'h01); // see RULE6 see RULE7
            end
            mbf_pkg::K_WRN: begin
                if (s_r.tx_i == `MBF_TX_COPY) begin
                    tb = s_r.crc[7:0];
                    crc_hold = 1'b1;
                end else if (s_r.tx_i == `MBF_TX_WRN_LAST) begin
                    tb = s_r.crc[15:8];
                    crc_hold = 1'b1;
                    tl = 1'b1;
                end
            end
            mbf_pkg::K_READ: begin
                if (s_r.tx_i == 6'h00) begin
                    tb = s_r.dst;
                end else if (s_r.tx_i == 6'h01) begin
                    tb = s_r.func;
                end else if (s_r.tx_i == 6'h02) begin
                    tb = {2'b00, q2}; // see RULE4
                end else if (s_r.tx_i < `MBF_TX_RDATA + q2) begin
                    tb = roff[0] ? reg_rdata[7:0] : reg_rdata[15:8]; // see RULE2
                end else if (s_r.tx_i == `MBF_TX_RDATA + q2) begin
                    tb = s_r.crc[7:0];
                    crc_hold = 1'b1;
                end else begin
                    tb = s_r.crc[15:8];
                    tl = 1'b1;
                    crc_hold = 1'b1;
                end
            end
            default: begin
                if (s_r.tx_i == 6'h00) begin
                    tb = s_r.dst;
                end else if (s_r.tx_i == 6'h01) begin
                    tb = s_r.func | `MBF_EXC_FLAG; // see RULE5
                end else if (s_r.tx_i == 6'h02) begin
                    tb = s_r.exc;
                end else if (s_r.tx_i == 6'h03) begin
                    tb = s_r.crc[7:0];
                    crc_hold = 1'b1;
                end else begin
                    tb = s_r.crc[15:8];
                    tl = (s_r.tx_i == `MBF_TX_ERR_LAST);
                    crc_hold = 1'b1;
                end
            end
        endcase
    end

    // ======================================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.wstb = 1'b0;
        pop = s_r.v0 && tx_ready;
        push = (s_r.st == mbf_pkg::S_TXB) && !s_r.v1;
        push_d = {tl, tb};
        case (s_r.st)
            mbf_pkg::S_IDLE, mbf_pkg::S_RX: begin
                if (rx_take) begin
                    s_nxt.st = mbf_pkg::S_RX;
                    s_nxt.crc = crc16_upd(s_r.crc, rx_data);
                    s_nxt.n = (s_r.n < `MBF_FRM_MAX) ? s_r.n + 7'h01 : s_r.n;
                    case (s_r.n)
                        `MBF_IX_ADDR: s_nxt.dst = rx_data;
                        `MBF_IX_FUNC: s_nxt.func = rx_data;
                        `MBF_IX_AHI: s_nxt.start[15:8] = rx_data;
                        `MBF_IX_ALO: s_nxt.start[7:0] = rx_data;
                        `MBF_IX_QHI: s_nxt.qty[15:8] = rx_data;
                        `MBF_IX_QLO: s_nxt.qty[7:0] = rx_data;
                        `MBF_IX_BCNT: s_nxt.bcnt = rx_data;
                        default: s_nxt.bcnt = s_r.bcnt;
                    endcase
                    if (rx_last) begin
                        s_nxt.st = mbf_pkg::S_CHECK;
                        s_nxt.rx_rdy = 1'b0;
                    end
                end
            end
            mbf_pkg::S_CHECK: begin
                s_nxt.st = mbf_pkg::S_TXA;
                s_nxt.kind = mbf_pkg::K_ERR;
                s_nxt.exc = `MBF_EXC_DATA;
                s_nxt.tx_i = 6'h00;
                s_nxt.k = 5'h00;
                s_nxt.crc = `MBF_CRC_INIT; // see RULE11
                case (s_r.func)
                    `MBF_FC_READ: begin
                        if (s_r.n == `MBF_LEN_FIX && s_r.qty != 16'h0000
                            && s_r.qty <= `MBF_MAX_QTY) begin
                            if (17'(s_r.start) + 17'(s_r.qty) > DEPTH) begin
                                s_nxt.exc = `MBF_EXC_ADDR;
                            end else begin
                                s_nxt.kind = mbf_pkg::K_READ; // see RULE1 see RULE10
                            end
                        end
                    end
                    `MBF_FC_WR1: begin
                        s_nxt.qty = 16'h0001;
                        if (s_r.n == `MBF_LEN_FIX) begin
                            if (17'(s_r.start) >= DEPTH) begin
                                s_nxt.exc = `MBF_EXC_ADDR;
                            end else begin
                                s_nxt.st = mbf_pkg::S_WR_HI; // see RULE10
                            end
                        end
                    end
                    `MBF_FC_LOOP: begin
                        if (s_r.n == `MBF_LEN_FIX) begin
                            s_nxt.kind = mbf_pkg::K_ECHO; // see RULE7 see RULE8
                        end
                    end
                    `MBF_FC_WRN: begin
                        if (s_r.qty != 16'h0000 && s_r.qty <= `MBF_MAX_QTY
                            && {2'b00, q2} == s_r.bcnt // see RULE3
                            && s_r.n == `MBF_LEN_WRN_HDR + s_r.bcnt[6:0]) begin
                            if (17'(s_r.start) + 17'(s_r.qty) > DEPTH) begin
                                s_nxt.exc = `MBF_EXC_ADDR;
                            end else begin
                                s_nxt.st = mbf_pkg::S_WR_HI; // see RULE10
                            end
                        end
                    end
                    default: s_nxt.exc = `MBF_EXC_FUNC;
                endcase
                // broadcast acts but stays silent, unknown station drops
                if (s_r.st == mbf_pkg::S_CHECK && s_nxt.st == mbf_pkg::S_TXA
                    && s_r.dst == `MBF_BCAST) begin
                    s_nxt.st = mbf_pkg::S_IDLE; // see RULE12
                end
                if (s_r.n >= `MBF_FRM_MAX || s_r.n < `MBF_LEN_MIN || s_r.crc != 16'h0000
                    || (s_r.dst != dev_addr && s_r.dst != `MBF_BCAST)) begin
                    s_nxt.st = mbf_pkg::S_IDLE; // see RULE13
                end
            end
            mbf_pkg::S_WR_HI: begin
                s_nxt.st = mbf_pkg::S_WR_LO;
            end
            mbf_pkg::S_WR_LO: begin
                s_nxt.hi = frm_rdata;
                s_nxt.st = mbf_pkg::S_WR_DO;
            end
            mbf_pkg::S_WR_DO: begin
                s_nxt.wstb = 1'b1;
                s_nxt.waddr = s_r.start + {11'h000, s_r.k};
                s_nxt.wdata = {s_r.hi, frm_rdata}; // see RULE2 see RULE6 see RULE9
                s_nxt.k = s_r.k + 5'h01;
                s_nxt.st = mbf_pkg::S_WR_HI;
                if ({11'h000, s_r.k} == s_r.qty - 16'h0001) begin
                    s_nxt.kind = (s_r.func == `MBF_FC_WRN) ? mbf_pkg::K_WRN : mbf_pkg::K_ECHO;
                    s_nxt.st = (s_r.dst == `MBF_BCAST) ? mbf_pkg::S_IDLE : mbf_pkg::S_TXA;
                end
            end
            mbf_pkg::S_TXA: begin
                s_nxt.st = mbf_pkg::S_TXB;
            end
            mbf_pkg::S_TXB: begin
                if (push) begin
                    s_nxt.crc = crc_hold ? s_r.crc : crc16_upd(s_r.crc, tb);
                    s_nxt.tx_i = s_r.tx_i + 6'h01;
                    s_nxt.st = tl ? mbf_pkg::S_IDLE : mbf_pkg::S_TXA;
                end
            end
            default: s_nxt.st = mbf_pkg::S_IDLE;
        endcase
        // a fresh frame always starts from a preset accumulator
        if (s_nxt.st == mbf_pkg::S_IDLE) begin
            s_nxt.rx_rdy = 1'b1;
            s_nxt.n = 7'h00;
            s_nxt.crc = `MBF_CRC_INIT; // see RULE11
        end
        // two-entry reply buffer, head in d0
        if (pop) begin
            s_nxt.d0 = s_r.v1 ? s_r.d1 : push_d;
            s_nxt.v0 = s_r.v1 || push;
            s_nxt.v1 = s_r.v1 && push;
            s_nxt.d1 = push_d;
        end else if (push) begin
            if (s_r.v0) begin
                s_nxt.d1 = push_d;
                s_nxt.v1 = 1'b1;
            end else begin
                s_nxt.d0 = push_d;
                s_nxt.v0 = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.rx_rdy <= 1'b1;
            s_r.crc <= `MBF_CRC_INIT;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign rx_ready = s_r.rx_rdy;
    assign tx_data = s_r.d0[7:0];
    assign tx_last = s_r.d0[8];
    assign tx_valid = s_r.v0;
    assign reg_wr_stb = s_r.wstb;
    assign reg_wr_addr = s_r.waddr[AW-1:0];
    assign reg_wr_data = s_r.wdata;

    // ======================================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_preset;
        (s_r.st == mbf_pkg::S_IDLE && rx_take) |=> s_r.crc == crc16_upd(`MBF_CRC_INIT, $past(rx_data));
    endproperty
    a_preset: assert property (p_preset) else $error("crc not preset"); // see RULE11

    property p_badcrc;
        (s_r.st == mbf_pkg::S_CHECK && s_r.crc != 16'h0000)
            |=> s_r.st == mbf_pkg::S_IDLE && s_r.rx_rdy && s_r.n == 7'h00;
    endproperty
    a_badcrc: assert property (p_badcrc) else $error("bad frame not dropped"); // see RULE13

    property p_bcast;
        (s_r.st == mbf_pkg::S_CHECK && s_r.dst == `MBF_BCAST) |=> s_r.st != mbf_pkg::S_TXA;
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast answered"); // see RULE12

    property p_bcount;
        (push && s_r.kind == mbf_pkg::K_READ && s_r.tx_i == 6'h02) |-> tb == {s_r.qty[6:0], 1'b0};
    endproperty
    a_bcount: assert property (p_bcount) else $error("read byte count wrong"); // see RULE4

    property p_errfunc;
        (push && s_r.kind == mbf_pkg::K_ERR && s_r.tx_i == 6'h01) |-> tb[7] && tb[6:0] == s_r.func[6:0];
    endproperty
    a_errfunc: assert property (p_errfunc) else $error("error function wrong"); // see RULE5

    property p_errlen;
        (push && s_r.kind == mbf_pkg::K_ERR) |-> tl == (s_r.tx_i == `MBF_TX_ERR_LAST);
    endproperty
    a_errlen: assert property (p_errlen) else $error("error reply length wrong"); // see RULE5

    property p_echo;
        (push && s_r.kind == mbf_pkg::K_ECHO) |-> tb == frm_rdata && frm_raddr == s_r.tx_i;
    endproperty
    a_echo: assert property (p_echo) else $error("echo byte changed"); // see RULE7

    property p_wdata;
        (s_r.st == mbf_pkg::S_WR_DO) |=> reg_wr_stb && reg_wr_data == {$past(s_r.hi), $past(frm_rdata)};
    endproperty
    a_wdata: assert property (p_wdata) else $error("stored value wrong"); // see RULE9

    property p_hilo;
        (push && s_r.kind == mbf_pkg::K_READ && s_r.tx_i >= `MBF_TX_RDATA && !roff[0]
            && s_r.tx_i < `MBF_TX_RDATA + q2) |-> tb == reg_rdata[15:8];
    endproperty
    a_hilo: assert property (p_hilo) else $error("upper byte not first"); // see RULE2

    c_read: cover property (push && tl && s_r.kind == mbf_pkg::K_READ);
    c_wrn: cover property (push && tl && s_r.kind == mbf_pkg::K_WRN);
    c_err: cover property (push && tl && s_r.kind == mbf_pkg::K_ERR);
    c_stall: cover property (s_r.v1 && !tx_ready);
endmodule

// ### src/mbf_ram.sv
// Purpose: small single-port-write, single-port-read memory
// Assumes: read data appear one clock after the read address
// Notes: used for the register map and for the request frame
`timescale 1ns/100ps
module mbf_ram #(
    parameter int W = 16,
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [0:(1<<AW)-1];

    // ======================================================================
    // write port, no reset on the array
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule

// ### verification/mbf_master_sink.sv
// Purpose: reply side of the bus master, takes reply bytes with stalls
// Assumes: ready moves only on the falling clock edge
// Notes: hold stalls fully, else ready is random about three cycles in four
`timescale 1ns/100ps
module mbf_master_sink (
    input wire logic clk,
    input wire logic rstn,
    input wire logic hold,
    output logic tx_ready
);
    // ======================================================================
    // ready pattern
    // random stalls, never ready during reset
    initial begin
        tx_ready = 1'b0;
        forever @(negedge clk) tx_ready <= rstn && !hold && ($urandom % 4 != 0);
    end
endmodule

// ### verification/tb_top.sv
// Purpose: self-checking bench of the function handler
// Assumes: requests driven on the falling edge, replies seen on the rising edge
// Notes: a local register image predicts read data
`timescale 1ns/100ps
module tb_top;
    logic clk;
    logic rstn;
    logic [7:0] dev_addr;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_last;
    logic rx_ready;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_last;
    logic tx_ready;
    logic hold;
    logic reg_wr_stb;
    logic [7:0] reg_wr_addr;
    logic [15:0] reg_wr_data;
    logic [7:0] fq[$];
    logic [7:0] rq[$];
    logic [8:0] exp_q[$];
    logic [23:0] wq[$];
    logic [15:0] mem[256];
    int err_count = 0;
    int compares = 0;

    // ======================================================================
    // design and partner
    mbf_handler i_mbf_handler (.clk(clk), .rstn(rstn), .dev_addr(dev_addr),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last),
        .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_ready(tx_ready), .reg_wr_stb(reg_wr_stb),
        .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
    mbf_master_sink i_mbf_master_sink (.clk(clk), .rstn(rstn), .hold(hold),
        .tx_ready(tx_ready));

    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ======================================================================
    // helpers
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, s, e);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction

    // word as upper byte then lower byte
    task automatic f16(input logic [15:0] v);
        fq.push_back(v[15:8]);
        fq.push_back(v[7:0]);
    endtask

    task automatic w16(input logic [15:0] v);
        rq.push_back(v[15:8]);
        rq.push_back(v[7:0]);
    endtask

    task automatic seal();
        logic [15:0] c;
        c = crc16(fq);
        fq.push_back(c[7:0]);
        fq.push_back(c[15:8]);
    endtask

    task automatic echo();
        foreach (fq[i]) exp_q.push_back({i == fq.size() - 1, fq[i]});
    endtask

    task automatic reply();
        logic [15:0] c;
        c = crc16(rq);
        rq.push_back(c[7:0]);
        rq.push_back(c[15:8]);
        foreach (rq[i]) exp_q.push_back({i == rq.size() - 1, rq[i]});
        rq.delete();
    endtask

    // hold the byte until a rising edge takes it
    task automatic send_byte(input logic [7:0] b, input logic l);
        rx_data = b;
        rx_valid = 1'b1;
        rx_last = l;
        while (rx_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
    endtask

    // whole frame, then wait for reply or silent drop
    task automatic send();
        int n;
        @(negedge clk);
        foreach (fq[i]) send_byte(fq[i], i == fq.size() - 1);
        rx_valid = 1'b0;
        rx_last = 1'b0;
        fq.delete();
        n = 0;
        while (rx_ready === 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while ((rx_ready !== 1'b1 || exp_q.size() != 0) && n < 3000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        chk(exp_q.size(), 0);
        chk(wq.size(), 0);
    endtask

    // ======================================================================
    // output watchers
    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            chk({tx_last, tx_data},
                exp_q.size() != 0 ? exp_q.pop_front() : 'x);
        end
    end

    // register stores in order
    always @(posedge clk) begin
        if (reg_wr_stb !== 1'b0) begin
            chk({reg_wr_addr, reg_wr_data}, wq.size() != 0 ? wq.pop_front() : 'x);
        end
    end

    // watchdog
    initial begin
        #400000;
        err_count++;
        stop_test();
    end

    // ======================================================================
    // scenarios
    initial begin
        logic [15:0] v;
        logic [7:0] s;
        void'($urandom(32'hD7F9));
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_last = 1'b0;
        hold = 1'b0;
        rstn = 1'b0;
        dev_addr = 8'h01 + 8'($urandom % 246);
        repeat (16) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        chk(crc16({8'h01, 8'h06, 8'h00, 8'h01, 8'h00, 8'h03}), 32'h0B98);
        // write one register, echoed reply
        v = 16'($urandom);
        fq = {dev_addr, 8'h06, 8'h00, 8'h01};
        f16(v);
        seal();
        echo();
        wq.push_back({8'h01, v});
        mem[1] = v;
        send();
        // write sixteen registers
        s = 8'($urandom % 241);
        fq = {dev_addr, 8'h10, 8'h00, s, 8'h00, 8'h10, 8'h20};
        rq = {dev_addr, 8'h10, 8'h00, s, 8'h00, 8'h10};
        for (int i = 0; i < 16; i++) begin
            v = 16'($urandom);
            f16(v);
            mem[8'(s + i)] = v;
            wq.push_back({8'(s + i), v});
        end
        seal();
        reply();
        send();
        // read them back while the receiver stalls
        rq = {dev_addr, 8'h03, 8'h20};
        for (int i = 0; i < 16; i++) w16(mem[8'(s + i)]);
        fq = {dev_addr, 8'h03, 8'h00, s, 8'h00, 8'h10};
        seal();
        reply();
        hold = 1'b1;
        fork
            begin
                repeat (80) @(negedge clk);
                hold = 1'b0;
            end
        join_none
        send();
        // single register read
        rq = {dev_addr, 8'h03, 8'h02};
        w16(mem[1]);
        fq = {dev_addr, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01};
        seal();
        reply();
        send();
        // loopback with master-chosen code and data
        repeat (2) begin
            fq = {dev_addr, 8'h08};
            f16(16'($urandom));
            f16(16'($urandom));
            seal();
            echo();
            send();
        end
        // refused requests
        for (int i = 0; i < 5; i++) begin
            case (i)
                0: fq = {dev_addr, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01};
                1: fq = {dev_addr, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
                2: fq = {dev_addr, 8'h03, 8'h00, 8'h00, 8'h00, 8'h11};
                3: fq = {dev_addr, 8'h03, 8'h01, 8'h00, 8'h00, 8'h01};
                default: fq = {dev_addr, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04,
                    8'h12, 8'h34, 8'h56, 8'h78};
            endcase
            rq = {dev_addr, fq[1] | 8'h80, i == 0 ? 8'h01 : i == 3 ? 8'h02 : 8'h03};
            seal();
            reply();
            send();
        end
        // broadcast write and read, both silent
        v = 16'($urandom);
        fq = {8'h00, 8'h06, 8'h00, 8'h05};
        f16(v);
        seal();
        wq.push_back({8'h05, v});
        mem[5] = v;
        send();
        fq = {8'h00, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01};
        seal();
        send();
        // bad crc and foreign station are dropped
        fq = {dev_addr, 8'h06, 8'h00, 8'h05, 8'hAA, 8'h55};
        seal();
        fq[7] = ~fq[7];
        send();
        fq = {dev_addr + 8'h01, 8'h06, 8'h00, 8'h05, 8'hAA, 8'h55};
        seal();
        send();
        // register left by broadcast only
        rq = {dev_addr, 8'h03, 8'h02};
        w16(mem[5]);
        fq = {dev_addr, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01};
        seal();
        reply();
        send();
        stop_test();
    end
endmodule
